// ### gpx_consts.vh
// register offsets, field positions and reset values of the port bank
`ifndef GPX_CONSTS_VH
`define GPX_CONSTS_VH

// register byte offsets
`define GPX_OFS_DOUT 8'h00
`define GPX_OFS_DIR 8'h04
`define GPX_OFS_DIN 8'h08
`define GPX_OFS_FUNC 8'h0c
`define GPX_OFS_IEN 8'h10
`define GPX_OFS_POL 8'h14
`define GPX_OFS_STAT 8'h18
`define GPX_OFS_CLR 8'h1c

// function select bits
`define GPX_FUNC_HP_GPIO 0
`define GPX_FUNC_CK6_GPIO 1
`define GPX_FUNC_CK4_GPIO 2

// status / enable layout
`define GPX_STAT_NMI 0
`define GPX_EXT_LSB 4
`define GPX_EXT_MSB 7

// reset values
`define GPX_RST_DOUT 16'h0000
`define GPX_RST_DIR 16'h0000
`define GPX_RST_FUNC 3'h0
`define GPX_RST_IEN 4'h0
`define GPX_RST_POL 4'h0

// divider ratios of the clock output pins
`define GPX_DIV6 6
`define GPX_DIV4 4

`endif

// ### gpx_sync_edge.v
// two-flop synchroniser with selectable-polarity edge detector
`timescale 1ns/1ps
module gpx_sync_edge (
  input wire clk,
  input wire rstn,
  input wire din,
  input wire pol,
  output wire level,
  output reg edge_evt
);
  ////////////////////////////////////////////////////////////////////////
  // first stage only feeds second stage (metastability guard)
  reg sync_a;
  // second stage, the usable synchronous level
  reg sync_b;
  // previous level for edge compare
  reg sync_c;
  // fills with ones after reset; its reset zero in sync_c would fake a
  // rising edge on a pulled-up pin, so edges count only once it is real
  reg [2:0] prime;

  // shift the pin through the stages
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      prime <= 3'h0;
    end else begin
      sync_a <= din;
      sync_b <= sync_a;
      sync_c <= sync_b;
      prime <= {prime[1:0], 1'b1};
    end
  end

  assign level = sync_b;

  ////////////////////////////////////////////////////////////////////////
  // one pulse per qualifying edge; pol low picks rising, high picks falling
  // R09: single event per edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      edge_evt <= 1'b0;
    end else if (!prime[2]) begin
      // no compare until sync_c holds a sampled pin level
      edge_evt <= 1'b0;
    end else if (pol) begin
      edge_evt <= sync_c & ~sync_b;
    end else begin
      edge_evt <= ~sync_c & sync_b;
    end
  end
endmodule // gpx_sync_edge

// ### gpx_pins.v
// pin logic of the general-purpose port bank with external interrupts
//
// Function
// R01: nmi raised on rising input edge
// R02: shared pins are gpio or interrupt input
// R03: after reset shared pins are inputs
// R04: enable bits 7..4 make edge interrupt
// R05: per-line polarity in bits 3..0
// R06: host data pins or port bits 15..8
// R07: bit 2 pin drives clock/6 by default
// R08: bit 1 pin drives clock/4 by default
// R09: synchronised, one event per edge
`timescale 1ns/1ps
`include "gpx_consts.vh"
module gpx_pins #(
  parameter AW = 8,
  parameter DW = 16,
  parameter DIV6 = `GPX_DIV6,
  parameter DIV4 = `GPX_DIV4
) (
  input wire clk,
  input wire rstn,
  // register port
  input wire [AW-1:0] reg_addr,
  input wire [DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [DW-1:0] reg_rdata,
  // port pins
  input wire [15:0] pin_in,
  output reg [15:0] pin_out,
  output reg [15:0] pin_oe,
  // nonmaskable interrupt pin
  input wire nmi_pin,
  // host port side of the shared data pins (same clock)
  input wire [7:0] host_port_data_out,
  input wire [7:0] host_port_data_oe,
  output reg [7:0] host_port_data_in,
  // events toward the core
  output reg nmi_evt,
  output reg [3:0] ext_irq_evt,
  output reg irq
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  reg [15:0] port_dout; // output latch of the port
  reg [15:0] port_dir; // 1 = drive pin
  reg [2:0] pin_func; // alternate function release bits
  reg [3:0] irq_enable_reg; // enable bits 7..4 of the layout
  reg [3:0] ext_irq_polarity_reg; // 0 rising, 1 falling
  reg [3:0] ext_stat; // sticky external events
  reg nmi_stat; // sticky nmi event
  reg [2:0] div6_cnt; // divide-by-six phase
  reg [1:0] div4_cnt; // divide-by-four phase
  reg clk_div6_out; // divided clock, three high, three low
  reg clk_div4_out; // divided clock, two high, two low
  wire [15:0] pin_level; // synchronised pin levels
  wire [15:0] pin_edge; // qualified edges per pin
  wire [15:0] pin_pol; // polarity per pin
  wire nmi_rise; // rising edge of nmi
  wire hp_mode; // high while host port owns 15..8
  wire ck6_mode; // high while bit 2 carries clock/6
  wire ck4_mode; // high while bit 1 carries clock/4
  wire wr_dout;
  wire wr_dir;
  wire wr_func;
  wire wr_ien;
  wire wr_pol;
  wire wr_clr;
  reg [15:0] next_pin_out;
  reg [15:0] next_pin_oe;
  reg [DW-1:0] next_rdata;
  reg [3:0] next_ext_stat;
  reg next_nmi_stat;

  ////////////////////////////////////////////////////////////////////////
  // write decode
  // a write lands on the edge that samples the strobe, no wait states
  assign wr_dout = reg_wr && (reg_addr == `GPX_OFS_DOUT);
  assign wr_dir = reg_wr && (reg_addr == `GPX_OFS_DIR);
  assign wr_func = reg_wr && (reg_addr == `GPX_OFS_FUNC);
  assign wr_ien = reg_wr && (reg_addr == `GPX_OFS_IEN);
  assign wr_pol = reg_wr && (reg_addr == `GPX_OFS_POL);
  assign wr_clr = reg_wr && (reg_addr == `GPX_OFS_CLR);

  // release bits low keep the alternate functions, the reset default
  assign hp_mode = ~pin_func[`GPX_FUNC_HP_GPIO];
  assign ck6_mode = ~pin_func[`GPX_FUNC_CK6_GPIO];
  assign ck4_mode = ~pin_func[`GPX_FUNC_CK4_GPIO];

  ////////////////////////////////////////////////////////////////////////
  // software registers
  // R03: inputs after reset
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_dout <= `GPX_RST_DOUT;
      port_dir <= `GPX_RST_DIR;
      pin_func <= `GPX_RST_FUNC;
      irq_enable_reg <= `GPX_RST_IEN;
      ext_irq_polarity_reg <= `GPX_RST_POL;
    end else begin
      if (wr_dout) begin
        port_dout <= reg_wdata[15:0];
      end
      if (wr_dir) begin
        port_dir <= reg_wdata[15:0];
      end
      if (wr_func) begin
        pin_func <= reg_wdata[2:0];
      end
      // R04: enable bits 7..4
      if (wr_ien) begin
        irq_enable_reg <= reg_wdata[`GPX_EXT_MSB:`GPX_EXT_LSB];
      end
      // R05: polarity bits 3..0
      if (wr_pol) begin
        ext_irq_polarity_reg <= reg_wdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detectors, one per port bit
  // every bit is synchronised, even pins owned by the host port or a
  // divided clock, so the input register always shows the pin level
  // R05: polarity per line
  assign pin_pol = {8'h00, ext_irq_polarity_reg, 4'h0};

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_pin
      gpx_sync_edge u_sync (
        .clk(clk),
        .rstn(rstn),
        .din(pin_in[gi]),
        .pol(pin_pol[gi]),
        .level(pin_level[gi]),
        .edge_evt(pin_edge[gi])
      );
    end
  endgenerate

  // R01: rising edge nmi
  gpx_sync_edge u_nmi_sync (
    .clk(clk),
    .rstn(rstn),
    .din(nmi_pin),
    .pol(1'b0),
    .level(),
    .edge_evt(nmi_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock dividers, free running from reset
  // the clock pins toggle before software touches anything; a pin handed
  // to gpio keeps its divider running, which costs a little power
  // R07: clock over six
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div6_cnt <= 3'h0;
      clk_div6_out <= 1'b0;
    end else begin
      if (div6_cnt == DIV6 - 1) begin
        div6_cnt <= 3'h0;
      end else begin
        div6_cnt <= div6_cnt + 3'h1;
      end
      // high for the first half of each period, even duty for even ratios
      clk_div6_out <= (div6_cnt < DIV6 / 2);
    end
  end

  // R08: clock over four
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div4_cnt <= 2'h0;
      clk_div4_out <= 1'b0;
    end else begin
      if (div4_cnt == DIV4 - 1) begin
        div4_cnt <= 2'h0;
      end else begin
        div4_cnt <= div4_cnt + 2'h1;
      end
      clk_div4_out <= (div4_cnt < DIV4 / 2);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin output mux
  always @* begin
    // plain gpio by default
    next_pin_out = port_dout;
    next_pin_oe = port_dir;
    // R06: host port owns 15..8
    if (hp_mode) begin
      next_pin_out[15:8] = host_port_data_out;
      next_pin_oe[15:8] = host_port_data_oe;
    end
    // R07: bit 2 clock
    if (ck6_mode) begin
      next_pin_out[2] = clk_div6_out;
      next_pin_oe[2] = 1'b1;
    end
    // R08: bit 1 clock
    if (ck4_mode) begin
      next_pin_out[1] = clk_div4_out;
      next_pin_oe[1] = 1'b1;
    end
    // later assignments win, so the input-only rule overrides the direction
    // R02: interrupt lines input-only
    next_pin_oe[`GPX_EXT_MSB:`GPX_EXT_LSB] = port_dir[`GPX_EXT_MSB:`GPX_EXT_LSB] &
                                             ~irq_enable_reg;
  end

  // registered pins; one cycle of latency keeps outputs glitch free
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 16'h0000;
      pin_oe <= 16'h0000;
      host_port_data_in <= 8'h00;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      host_port_data_in <= pin_level[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status; a new event wins over a clear in the same cycle
  always @* begin
    next_ext_stat = ext_stat;
    next_nmi_stat = nmi_stat;
    if (wr_clr) begin
      next_ext_stat = ext_stat & ~reg_wdata[`GPX_EXT_MSB:`GPX_EXT_LSB];
      next_nmi_stat = nmi_stat & ~reg_wdata[`GPX_STAT_NMI];
    end
    // R04: enabled edges only
    next_ext_stat = next_ext_stat | (pin_edge[`GPX_EXT_MSB:`GPX_EXT_LSB] & irq_enable_reg);
    // nmi has no enable bit, so its flag feeds irq straight
    // R01: nmi ignores enables
    next_nmi_stat = next_nmi_stat | nmi_rise;
  end

  // status flops and event outputs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_stat <= 4'h0;
      nmi_stat <= 1'b0;
      ext_irq_evt <= 4'h0;
      nmi_evt <= 1'b0;
      irq <= 1'b0;
    end else begin
      ext_stat <= next_ext_stat;
      nmi_stat <= next_nmi_stat;
      // R09: one pulse per edge
      ext_irq_evt <= pin_edge[`GPX_EXT_MSB:`GPX_EXT_LSB] & irq_enable_reg;
      nmi_evt <= nmi_rise;
      // irq takes the next flag values, so it rises with the status bit
      // and drops on the edge that lands the clear; nmi cannot be masked
      irq <= (|(next_ext_stat & irq_enable_reg)) | next_nmi_stat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped and write-only offsets read zero
  always @* begin
    next_rdata = {DW{1'b0}};
    case (reg_addr)
      `GPX_OFS_DOUT: begin
        next_rdata[15:0] = port_dout;
      end
      `GPX_OFS_DIR: begin
        next_rdata[15:0] = port_dir;
      end
      `GPX_OFS_DIN: begin
        next_rdata[15:0] = pin_level;
      end
      `GPX_OFS_FUNC: begin
        next_rdata[2:0] = pin_func;
      end
      `GPX_OFS_IEN: begin
        next_rdata[`GPX_EXT_MSB:`GPX_EXT_LSB] = irq_enable_reg;
      end
      `GPX_OFS_POL: begin
        next_rdata[3:0] = ext_irq_polarity_reg;
      end
      `GPX_OFS_STAT: begin
        next_rdata[`GPX_EXT_MSB:`GPX_EXT_LSB] = ext_stat;
        next_rdata[`GPX_STAT_NMI] = nmi_stat;
      end
      default: begin
        next_rdata = {DW{1'b0}};
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= {DW{1'b0}};
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= {DW{1'b0}};
    end
  end
endmodule // gpx_pins

// ### gpx_pins_properties.sv
// checker of the port bank pin behaviour
`timescale 1ns/1ps
module gpx_pins_properties #(
  parameter DIV6 = 6,
  parameter DIV4 = 4
) (
  input wire clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [15:0] pin_in,
  input wire [15:0] pin_out,
  input wire [15:0] pin_oe,
  input wire nmi_pin,
  input wire [7:0] host_port_data_out,
  input wire [7:0] host_port_data_oe,
  input wire [7:0] host_port_data_in,
  input wire nmi_evt,
  input wire [3:0] ext_irq_evt,
  input wire irq
);
  // half periods of the two divided clocks, and one cycle beyond them
  localparam int H6 = DIV6 / 2;
  localparam int H4 = DIV4 / 2;
  localparam int P6 = H6 + 1;
  localparam int P4 = H4 + 1;
  // recent writes or a reset may retarget the clock pins, so clock checks
  // skip them; five cycles of history cover ratios up to seven
  reg [4:0] wr_h;
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      wr_h <= 5'h1f;
    else
      wr_h <= {wr_h[3:0], reg_wr};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  nmi_edge_a: assert property ($rose(nmi_pin) && $past(rstn) |-> ##[1:6] nmi_evt)
    else $error("nmi edge without event");
  ext_once_a: assert property ((ext_irq_evt & $past(ext_irq_evt)) == 4'h0)
    else $error("ext event longer than one cycle");
  ext_irq_a: assert property (ext_irq_evt != 4'h0 |-> irq)
    else $error("ext event without irq");
  irq_fall_a: assert property ($fell(irq) |-> wr_h[0])
    else $error("irq dropped without a write");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  rst_oe_a: assert property ($rose(rstn) |-> ((pin_oe & 16'h00f9) == 16'h0000) [*2])
    else $error("pin driven after reset");
  div6_a: assert property ($fell(pin_out[2]) && wr_h == 5'h00 |->
                           $past(pin_out[2], H6) && !$past(pin_out[2], P6))
    else $error("div6 high phase wrong");
  div4_a: assert property ($rose(pin_out[1]) && wr_h == 5'h00 |->
                           !$past(pin_out[1], H4) && $past(pin_out[1], P4))
    else $error("div4 low phase wrong");
  cover property ($rose(pin_out[2]));
  cover property (nmi_evt);
  cover property (ext_irq_evt[3]);
  cover property ($fell(irq));
endmodule // gpx_pins_properties
bind gpx_pins gpx_pins_properties #(.DIV6(DIV6), .DIV4(DIV4)) u_chk (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .nmi_pin(nmi_pin),
  .host_port_data_out(host_port_data_out), .host_port_data_oe(host_port_data_oe),
  .host_port_data_in(host_port_data_in), .nmi_evt(nmi_evt),
  .ext_irq_evt(ext_irq_evt), .irq(irq)
);

// ### gpx_board.sv
// board model: pin pulls and external sources of the port bank
`timescale 1ns/1ps
module gpx_board (
  input wire [15:0] pin_out,
  input wire [15:0] pin_oe,
  input wire [15:0] ext_val,
  input wire [15:0] ext_oe,
  output wire [15:0] pin_in
);
  // pins 3 and 0 pull down, the rest pull up
  localparam [15:0] PULL = 16'hfff6;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe & PULL);
endmodule // gpx_board

// ### gpx_pins_tb.sv
// testbench of the port bank pin logic
`timescale 1ns/1ps
`include "gpx_consts.vh"
module gpx_pins_tb;
  reg clk, rstn, reg_wr, reg_rd, nmi_pin;
  reg [7:0] reg_addr, hp_out, hp_oe;
  reg [15:0] reg_wdata, ext_val, ext_oe;
  wire [15:0] reg_rdata, pin_in, pin_out, pin_oe;
  wire [7:0] hp_in;
  wire [3:0] ext_irq_evt;
  wire nmi_evt, irq;
  integer error_cnt = 0, check_count = 0, cyc = 0, nmi_n = 0, i, j;
  integer ext_n [0:3] = '{0, 0, 0, 0};
  gpx_pins u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .nmi_pin(nmi_pin), .host_port_data_out(hp_out),
    .host_port_data_oe(hp_oe), .host_port_data_in(hp_in), .nmi_evt(nmi_evt),
    .ext_irq_evt(ext_irq_evt), .irq(irq));
  gpx_board u_brd (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_oe(ext_oe), .pin_in(pin_in));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task report_and_stop;
    if (error_cnt == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [7:0] a, input [15:0] exp, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, exp, reg_rdata);
  endtask
  // count event pulses and cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (nmi_evt === 1'b1) nmi_n <= nmi_n + 1;
    for (i = 0; i < 4; i++) if (ext_irq_evt[i] === 1'b1) ext_n[i] <= ext_n[i] + 1;
    if (cyc == 2000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    nmi_pin = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    hp_out = 8'h3c;
    hp_oe = 8'hff;
    ext_val = 16'h00a8;
    ext_oe = 16'h00f9;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    // defaults: inputs, clock pins driven, host owns the data pins
    rd(`GPX_OFS_DIR, 16'h0000, "dir");
    rd(`GPX_OFS_FUNC, 16'h0000, "func");
    rd(8'h20, 16'h0000, "unmapped");
    chk("oe", 16'hff06, pin_oe);
    chk("host in", 16'h003c, {8'h00, hp_in});
    // nmi rising edge once, falling edge ignored
    @(posedge clk) nmi_pin <= 1'b1;
    repeat (6) @(posedge clk);
    rd(`GPX_OFS_STAT, 16'h0001, "nmi stat");
    chk("nmi irq", 16'h0001, {15'h0, irq});
    wr(`GPX_OFS_CLR, 16'h0001);
    @(posedge clk) nmi_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rd(`GPX_OFS_STAT, 16'h0000, "nmi clr");
    chk("nmi cnt", 16'h0001, nmi_n[15:0]);
    // edges on disabled lines stay silent
    @(posedge clk) ext_val <= 16'h0058;
    repeat (6) @(posedge clk);
    @(posedge clk) ext_val <= 16'h00a8;
    repeat (6) @(posedge clk);
    rd(`GPX_OFS_STAT, 16'h0000, "off stat");
    // lines 1 and 3 falling, 0 and 2 rising
    wr(`GPX_OFS_POL, 16'h000a);
    wr(`GPX_OFS_IEN, 16'h00f0);
    wr(`GPX_OFS_DIR, 16'hfff9);
    rd(`GPX_OFS_POL, 16'h000a, "pol");
    rd(`GPX_OFS_IEN, 16'h00f0, "ien");
    @(posedge clk) ext_val <= 16'h0058;
    repeat (6) @(posedge clk);
    rd(`GPX_OFS_STAT, 16'h00f0, "ext stat");
    chk("ext oe", 16'h0000, pin_oe & 16'h00f0);
    @(posedge clk) ext_val <= 16'h00a8;
    repeat (6) @(posedge clk);
    for (j = 0; j < 4; j++) chk("ext cnt", 16'h0001, ext_n[j][15:0]);
    wr(`GPX_OFS_CLR, 16'h00f0);
    rd(`GPX_OFS_STAT, 16'h0000, "ext clr");
    chk("irq off", 16'h0000, {15'h0, irq});
    rd(`GPX_OFS_CLR, 16'h0000, "wo read");
    // host and clock pins become port bits; host drive off, pins 2 and 1 inputs
    @(posedge clk) hp_oe <= 8'h00;
    wr(`GPX_OFS_DOUT, 16'ha500);
    wr(`GPX_OFS_FUNC, 16'h0007);
    repeat (5) @(posedge clk);
    #1 chk("gp out", 16'ha500, pin_out & 16'hff06);
    chk("gp oe", 16'hff00, pin_oe & 16'hff06);
    chk("gp in", 16'h00a5, {8'h00, hp_in});
    rd(`GPX_OFS_DIN, 16'ha5a6, "din");
    report_and_stop;
  end
endmodule // gpx_pins_tb
